/* rtl/lecnt_top.sv */
// lane error counters with hold control, status and irq behind an ahb-lite slave
`timescale 1ns/10ps
`include "lecnt_map.svh"
module lecnt_top (
  input wire logic hclk,                  // 100 mhz clock
  input wire logic hresetn,               // async reset, active low
  input wire logic hsel,                  // slave select
  input wire logic [31:0] haddr,          // byte address
  input wire logic [1:0] htrans,          // transfer type
  input wire logic hwrite,                // write when high
  input wire logic [2:0] hsize,           // transfer size
  input wire logic hready,                // bus ready in
  input wire logic [31:0] hwdata,         // write data
  output logic [31:0] hrdata,             // read data
  output logic hreadyout,                 // always ready
  output logic hresp,                     // always okay
  input wire logic unexpected_control_char_error, // lane 0 error pulse, same clock
  input wire logic code_not_in_table_error,       // lane 0 error pulse, same clock
  input wire logic bad_disparity_error,           // lane 0 error pulse, same clock
  output logic link_decoder_soft_reset,   // decoder held in soft reset
  output logic [2:0] lane6_saturate_select, // lane 6 hold field
  output logic [2:0] lane7_saturate_select, // lane 7 hold field
  output logic irq                        // level interrupt
);
  // ----------------------------------------------------------------
  // bus address phase capture
  // ----------------------------------------------------------------
  lecnt_pkg::lecnt_bus_t phase_q;
  lecnt_pkg::lecnt_bus_t phase_d;
  logic [11:0] idx_q;
  logic [11:0] idx_d;

  always_comb begin
    phase_d = lecnt_pkg::LECNT_BUS_IDLE;
    idx_d = idx_q;
    if (hsel && hready && htrans[1]) begin
      phase_d = hwrite ? lecnt_pkg::LECNT_BUS_WRITE : lecnt_pkg::LECNT_BUS_READ;
      idx_d = haddr[13:2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= lecnt_pkg::LECNT_BUS_IDLE;
      idx_q <= 12'h000;
    end else begin
      phase_q <= phase_d;
      idx_q <= idx_d;
    end
  end

  wire wr = (phase_q == lecnt_pkg::LECNT_BUS_WRITE);
  wire rd = (phase_q == lecnt_pkg::LECNT_BUS_READ);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  lecnt_pkg::lecnt_sel_t hold0_q;
  lecnt_pkg::lecnt_sel_t hold0_d;
  lecnt_pkg::lecnt_sel_t hold6_q;
  lecnt_pkg::lecnt_sel_t hold6_d;
  lecnt_pkg::lecnt_sel_t hold7_q;
  lecnt_pkg::lecnt_sel_t hold7_d;
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  lecnt_pkg::lecnt_sel_t mask_q;
  lecnt_pkg::lecnt_sel_t mask_d;

  // writes land whenever they come; keeping them to soft reset is software's job
  always_comb begin
    hold0_d = hold0_q;
    hold6_d = hold6_q;
    hold7_d = hold7_q;
    mask_d = mask_q;
    ctrl_d = ctrl_q;
    ctrl_d[`LECNT_CTRL_CLR_BIT] = 1'b0; // clear is self-resetting
    if (wr) begin
      unique case (idx_q)
        `LECNT_IDX_LANE0_HOLD: hold0_d = hwdata[2:0];
        `LECNT_IDX_LANE6_HOLD: hold6_d = hwdata[2:0];
        `LECNT_IDX_LANE7_HOLD: hold7_d = hwdata[2:0];
        `LECNT_IDX_IRQ_MASK: mask_d = hwdata[2:0];
        `LECNT_IDX_LANE0_CTRL: ctrl_d = hwdata[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold0_q <= `LECNT_HOLD_RESET;
      hold6_q <= `LECNT_HOLD_RESET;
      hold7_q <= `LECNT_HOLD_RESET;
      mask_q <= 3'h0;
      ctrl_q <= `LECNT_CTRL_RESET;
    end else begin
      hold0_q <= hold0_d;
      hold6_q <= hold6_d;
      hold7_q <= hold7_d;
      mask_q <= mask_d;
      ctrl_q <= ctrl_d;
    end
  end

  wire soft_rst = ctrl_q[`LECNT_CTRL_SRST_BIT];
  wire cnt_clear = ctrl_q[`LECNT_CTRL_CLR_BIT] | soft_rst;

  // ----------------------------------------------------------------
  // lane 0 counters
  // ----------------------------------------------------------------
  logic [2:0] err_v;
  logic [2:0] term_p;
  logic [7:0] cnt [3];
  assign err_v[`LECNT_BIT_UEK] = unexpected_control_char_error & ~soft_rst;
  assign err_v[`LECNT_BIT_NIT] = code_not_in_table_error & ~soft_rst;
  assign err_v[`LECNT_BIT_BDE] = bad_disparity_error & ~soft_rst;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cnt
      lecnt_counter u_cnt (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(cnt_clear),
        .err(err_v[gi]),
        .hold_en(hold0_q[gi]),
        .count(cnt[gi]),
        .terminal(term_p[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // status: terminal reached and interrupt flags
  // ----------------------------------------------------------------
  logic [2:0] reach_q;
  logic [2:0] reach_d;
  logic [2:0] ista_q;
  logic [2:0] ista_d;
  logic ista_clr;

  // a status read clears the irq flags at the end of its data phase
  assign ista_clr = rd && (idx_q == `LECNT_IDX_IRQ_STAT);

  always_comb begin
    // a terminal event wins over a clear that falls in the same cycle
    reach_d = (cnt_clear ? 3'h0 : reach_q) | term_p;
    ista_d = (ista_clr ? 3'h0 : ista_q) | term_p;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reach_q <= 3'h0;
      ista_q <= 3'h0;
    end else begin
      reach_q <= reach_d;
      ista_q <= ista_d;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic rd_take;
  logic [31:0] rdata_d;

  // the mux reads next values for all but the counts, so a flag raised or a register written in the
  // address phase cycle is returned as it will stand, and no irq event is lost
  assign rd_take = hsel && hready && htrans[1] && !hwrite;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_take) begin
      unique case (idx_d)
        `LECNT_IDX_LANE0_HOLD: rdata_d[2:0] = hold0_d;
        `LECNT_IDX_LANE6_HOLD: rdata_d[2:0] = hold6_d;
        `LECNT_IDX_LANE7_HOLD: rdata_d[2:0] = hold7_d;
        `LECNT_IDX_LANE0_STAT: begin
          rdata_d[`LECNT_LANE_ENA_BIT] = ~ctrl_d[`LECNT_CTRL_SRST_BIT];
          rdata_d[2:0] = reach_d;
        end
        `LECNT_IDX_LANE0_CTRL: rdata_d[1:0] = ctrl_d;
        `LECNT_IDX_LANE0_CNT: rdata_d[23:0] = {cnt[2], cnt[1], cnt[0]};
        `LECNT_IDX_IRQ_STAT: rdata_d[2:0] = ista_d;
        `LECNT_IDX_IRQ_MASK: rdata_d[2:0] = mask_d;
        default: ;
      endcase
    end
  end

  // outside a read data phase the bus sees zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic irq_d;

  // next flag and mask values keep irq in step with the registers it mirrors
  always_comb begin
    irq_d = |(ista_d & mask_d);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
      link_decoder_soft_reset <= 1'b1;
      lane6_saturate_select <= `LECNT_HOLD_RESET;
      lane7_saturate_select <= `LECNT_HOLD_RESET;
    end else begin
      irq <= irq_d;
      link_decoder_soft_reset <= ctrl_d[`LECNT_CTRL_SRST_BIT];
      lane6_saturate_select <= hold6_d;
      lane7_saturate_select <= hold7_d;
    end
  end

  // ----------------------------------------------------------------
  // fixed bus answers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule

/* inc/lecnt_map.svh */
// register offsets, field positions, reset values and counts of the lane error counter block
`ifndef LECNT_MAP_SVH
`define LECNT_MAP_SVH

// printed register indices; byte address is four times the index
`define LECNT_IDX_LANE6_HOLD 12'h48e
`define LECNT_IDX_LANE7_HOLD 12'h48f
`define LECNT_IDX_LANE0_STAT 12'h490
// own registers
`define LECNT_IDX_LANE0_HOLD 12'h4a0
`define LECNT_IDX_LANE0_CTRL 12'h4a1
`define LECNT_IDX_LANE0_CNT  12'h4a2
`define LECNT_IDX_IRQ_STAT   12'h4a3
`define LECNT_IDX_IRQ_MASK   12'h4a4

`define LECNT_HOLD_RESET  3'h7
`define LECNT_TERMINAL    8'hff
`define LECNT_LANE_ENA_BIT 3
`define LECNT_BIT_UEK 2
`define LECNT_BIT_NIT 1
`define LECNT_BIT_BDE 0
// control register fields
`define LECNT_CTRL_SRST_BIT 0
`define LECNT_CTRL_CLR_BIT  1
`define LECNT_CTRL_RESET    2'h1

`endif

/* inc/lecnt_pkg.sv */
// types shared by the lane error counter block
package lecnt_pkg;
  typedef enum logic [1:0] {
    LECNT_BUS_IDLE,
    LECNT_BUS_WRITE,
    LECNT_BUS_READ
  } lecnt_bus_t;
  typedef logic [2:0] lecnt_sel_t;
endpackage

/* rtl/lecnt_counter.sv */
// one 8-bit error counter with hold or rollover at terminal count
`timescale 1ns/10ps
`include "lecnt_map.svh"
module lecnt_counter (
  input wire logic hclk,           // system clock
  input wire logic hresetn,        // async reset, active low
  input wire logic clear,          // synchronous counter reset
  input wire logic err,            // one error seen this cycle
  input wire logic hold_en,        // saturate when set
  output logic [7:0] count,        // current count
  output logic terminal            // pulse when count reaches terminal value
);
  logic [7:0] count_d;
  logic terminal_d;

  always_comb begin
    count_d = count;
    terminal_d = 1'b0;
    if (clear) begin
      count_d = 8'h00;
    end else if (err) begin
      if (count == `LECNT_TERMINAL) begin
        if (!hold_en) begin
          count_d = 8'h00;
        end
      end else begin
        count_d = count + 8'h01;
        terminal_d = (count_d == `LECNT_TERMINAL);
      end
    end
    // at terminal with hold set the count stays
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 8'h00;
      terminal <= 1'b0;
    end else begin
      count <= count_d;
      terminal <= terminal_d;
    end
  end
endmodule

/* test/lecnt_top_sva.sv */
// assertions on the lane error counter block ports
`timescale 1ns/10ps
module lecnt_top_sva (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // type
  input wire logic hwrite, // write
  input wire logic hready, // ready in
  input wire logic [31:0] hwdata, // wdata
  input wire logic [31:0] hrdata, // rdata
  input wire logic hreadyout, // ready out
  input wire logic hresp, // resp
  input wire logic link_decoder_soft_reset, // soft reset
  input wire logic [2:0] lane6_saturate_select, // lane 6
  input wire logic [2:0] lane7_saturate_select // lane 7
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic [3:0] ph_d, ph_q; // data phase of read, lane6, lane7, ctrl write
  assign take = hsel && hready && htrans[1];
  always_comb begin
    ph_d[0] = take && !hwrite;
    ph_d[1] = take && hwrite && haddr == 32'h0000_1238;
    ph_d[2] = take && hwrite && haddr == 32'h0000_123c;
    ph_d[3] = take && hwrite && haddr == 32'h0000_1284;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 4'h0;
    end else begin
      ph_q <= ph_d;
    end
  end
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
  a_reset_vals: assert property ($rose(hresetn) |-> link_decoder_soft_reset &&
    lane6_saturate_select == 3'h7 && lane7_saturate_select == 3'h7) else $error("bad reset outputs");
  a_rdata_idle: assert property (!ph_q[0] |-> hrdata == 32'h0) else $error("read data outside read");
  a_lane6_write: assert property (ph_q[1] |=> lane6_saturate_select == $past(hwdata[2:0]))
    else $error("lane6 field not written");
  a_lane7_write: assert property (ph_q[2] |=> lane7_saturate_select == $past(hwdata[2:0]))
    else $error("lane7 field not written");
  a_lane6_hold: assert property (!ph_q[1] |=> $stable(lane6_saturate_select))
    else $error("lane6 field moved");
  a_ctrl_write: assert property (ph_q[3] |=> link_decoder_soft_reset == $past(hwdata[0]))
    else $error("soft reset not written");
  a_soft_hold: assert property (!ph_q[3] |=> $stable(link_decoder_soft_reset))
    else $error("soft reset moved");
endmodule
bind lecnt_top lecnt_top_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .hrdata, .hreadyout, .hresp, .link_decoder_soft_reset, .lane6_saturate_select, .lane7_saturate_select);

/* test/lecnt_lane_src.sv */
// far-end lane model that sends bursts of error code groups
`timescale 1ns/10ps
module lecnt_lane_src (
  input wire logic hclk, // clock
  input wire logic start, // load a burst
  input wire logic [2:0] kind, // error lines to raise
  input wire logic [8:0] num, // code groups in burst
  input wire logic slow, // one group every other cycle
  output logic [2:0] err, // error pulses
  output logic busy // burst in flight
);
  logic [8:0] left;
  logic gap;
  initial begin
    left = 9'h0;
    gap = 1'b0;
    err = 3'h0;
  end
  always @(posedge hclk) begin
    gap <= ~gap;
    if (start) begin
      left <= num;
      err <= 3'h0;
    end else if (left != 9'h0 && (!slow || gap)) begin
      err <= kind;
      left <= left - 9'h1;
    end else begin
      err <= 3'h0;
    end
  end
  assign busy = left != 9'h0 || err != 3'h0;
endmodule

/* test/test_lecnt_top.sv */
// self-checking bench for the lane error counter block
`timescale 1ns/10ps
module test_lecnt_top;
  logic hclk, hresetn, hsel, hwrite, hready, start, slow, hreadyout, hresp, sr, irq, busy;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, t;
  logic [2:0] kind, err, sel6, sel7;
  logic [8:0] num;
  int bad_count, compares, cyc;
  assign hready = hreadyout;
  lecnt_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready, .hwdata, .hrdata,
    .hreadyout, .hresp, .unexpected_control_char_error(err[2]), .code_not_in_table_error(err[1]),
    .bad_disparity_error(err[0]), .link_decoder_soft_reset(sr), .lane6_saturate_select(sel6),
    .lane7_saturate_select(sel7), .irq);
  lecnt_lane_src src (.hclk, .start, .kind, .num, .slow, .err, .busy);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic wrap_up;
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      $display("BAD %0t timeout", $time);
      wrap_up;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    t = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(t, exp);
  endtask
  task automatic errs(input logic [2:0] k, input logic [8:0] n, input logic s);
    @(posedge hclk);
    start <= 1'b1;
    kind <= k;
    num <= n;
    slow <= s;
    @(posedge hclk);
    start <= 1'b0;
    do @(posedge hclk); while (busy);
    // the reached flag and irq trail the last counted error by one edge
    @(posedge hclk);
  endtask
  initial begin
    {hsel, hwrite, start, slow, htrans, haddr, hwdata, kind, num} = '0;
    hresetn = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'h1238, 32'h7);
    rd(32'h123c, 32'h7);
    rd(32'h1280, 32'h7);
    rd(32'h1240, 32'h0);
    rd(32'h1000, 32'h0);
    bus(1'b1, 32'h1238, 32'hffff_fffd);
    bus(1'b1, 32'h123c, 32'h2);
    rd(32'h1238, 32'h5);
    chk({26'h0, sel6, sel7}, 32'h2a);
    bus(1'b1, 32'h1280, 32'h5);
    bus(1'b1, 32'h1290, 32'h7);
    bus(1'b1, 32'h1284, 32'h0);
    rd(32'h1240, 32'h8);
    chk({31'h0, sr}, 32'h0);
    errs(3'h7, 9'd255, 1'b1);
    chk({31'h0, irq}, 32'h1);
    rd(32'h1288, 32'h00ff_ffff);
    rd(32'h1240, 32'hf);
    rd(32'h128c, 32'h7);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    errs(3'h7, 9'd2, 1'b0);
    rd(32'h1288, 32'h00ff_01ff);
    bus(1'b1, 32'h1290, 32'h0);
    bus(1'b1, 32'h1284, 32'h2);
    rd(32'h128c, 32'h0);
    errs(3'h2, 9'd255, 1'b0);
    chk({31'h0, irq}, 32'h0);
    rd(32'h128c, 32'h2);
    rd(32'h1288, 32'h0000_ff00);
    bus(1'b1, 32'h1284, 32'h1);
    errs(3'h7, 9'd3, 1'b0);
    rd(32'h1240, 32'h0);
    rd(32'h1288, 32'h0);
    chk({31'h0, sr}, 32'h1);
    wrap_up;
  end
endmodule
